// [rtl/qld_control.sv]
// Control and protection logic of a four-channel low-side switch
module qld_control #(
  parameter int unsigned DEGLITCH_CYCLES = qld_pkg::DEGLITCH_CYC,
  parameter int unsigned RETRY_CYCLES    = qld_pkg::RETRY_CYC
) (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset_n,
  input  wire logic                          i_clk_en,
  input  wire logic                          i_reset,
  input  wire logic                          i_reset_oe,
  input  wire logic                          i_output_enable_n,
  input  wire logic                          i_output_enable_n_oe,
  input  wire logic [qld_pkg::CHANNELS-1:0]  i_channel_input,
  input  wire qld_pkg::qld_sense_t           i_sense,
  output logic      [qld_pkg::CHANNELS-1:0]  o_channel_output,
  output logic                               o_fault_flag_n,
  output logic                               o_fault_flag_n_oe,
  output logic      [qld_pkg::CHANNELS-1:0]  o_oc_fault
);

  // ****************************************
  // Input conditioning
  // ****************************************
  logic reset_pin;
  logic enable_n_pin;
  logic logic_reset;

  // Undriven pins read through internal pulldowns
  assign reset_pin    = i_reset_oe & i_reset;
  assign enable_n_pin = i_output_enable_n_oe & i_output_enable_n;
  // i_reset_n models power-up reset; supply low also clears all state
  assign logic_reset  = reset_pin | i_sense.supply_low;

  function automatic logic [qld_pkg::CNT_W-1:0] dec(input logic [qld_pkg::CNT_W-1:0] c);
    dec = (c == qld_pkg::CNT_ZERO) ? qld_pkg::CNT_ZERO : c - qld_pkg::CNT_ONE;
  endfunction

  localparam logic [qld_pkg::CNT_W-1:0] DEG_LOAD = qld_pkg::CNT_W'(DEGLITCH_CYCLES);
  localparam logic [qld_pkg::CNT_W-1:0] RET_LOAD = qld_pkg::CNT_W'(RETRY_CYCLES - 1);

  // ****************************************
  // Per-channel protection
  // ****************************************
  qld_pkg::qld_chan_t chan      [qld_pkg::CHANNELS];
  qld_pkg::qld_chan_t next_chan [qld_pkg::CHANNELS];

  always_comb begin
    for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
      next_chan[i] = chan[i];
      if (logic_reset) begin
        next_chan[i].state = qld_pkg::QLD_RUN;
        next_chan[i].cnt   = DEG_LOAD;
      end else begin
        case (chan[i].state)
          qld_pkg::QLD_RUN: begin
            if (!i_sense.current_limit[i]) begin
              next_chan[i].cnt = DEG_LOAD;
            end else if (chan[i].cnt == qld_pkg::CNT_ONE) begin
              // Limit held a full deglitch interval
              next_chan[i].state = qld_pkg::QLD_RETRY;
              next_chan[i].cnt   = RET_LOAD;
            end else begin
              next_chan[i].cnt = dec(chan[i].cnt);
            end
          end
          qld_pkg::QLD_RETRY: begin
            if (chan[i].cnt == qld_pkg::CNT_ZERO) begin
              next_chan[i].state = qld_pkg::QLD_RUN;
              next_chan[i].cnt   = DEG_LOAD;
            end else begin
              next_chan[i].cnt = dec(chan[i].cnt);
            end
          end
          default: begin
            next_chan[i].state = qld_pkg::QLD_RUN;
            next_chan[i].cnt   = DEG_LOAD;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
        chan[i] <= '{state: qld_pkg::QLD_RUN, cnt: DEG_LOAD};
      end
    end else if (i_clk_en) begin
      for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
        chan[i] <= next_chan[i];
      end
    end
  end

  // ****************************************
  // Output drive and fault line
  // ****************************************
  logic [qld_pkg::CHANNELS-1:0] oc_active;
  logic [qld_pkg::CHANNELS-1:0] next_out;
  logic                         next_fault_n;
  logic                         out_fault_n;
  logic [qld_pkg::CHANNELS-1:0] out_drive;

  always_comb begin
    for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
      oc_active[i] = (chan[i].state == qld_pkg::QLD_RETRY);
    end
    // Reset masks every control input; thermal trip kills all switches
    if (logic_reset || enable_n_pin || i_sense.thermal_trip) begin
      next_out = '0;
    end else begin
      next_out = i_channel_input & ~oc_active;
    end
    // Fault pulled low only while a trip is live
    next_fault_n = ~((|oc_active) | i_sense.thermal_trip) | logic_reset;
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      out_drive   <= '0;
      out_fault_n <= 1'b1;
    end else if (i_clk_en) begin
      out_drive   <= next_out;
      out_fault_n <= next_fault_n;
    end
  end

  assign o_channel_output  = out_drive;
  assign o_fault_flag_n    = out_fault_n;
  assign o_fault_flag_n_oe = ~out_fault_n;
  assign o_oc_fault        = oc_active;

  // ****************************************
  // Checker helpers
  // ****************************************
  // Run lengths of the limit and of the retry hold, per channel; counting here
  // keeps the timing checks short instead of unrolling thousands of cycles
  logic [qld_pkg::CNT_W-1:0] limit_run      [qld_pkg::CHANNELS];
  logic [qld_pkg::CNT_W-1:0] next_limit_run [qld_pkg::CHANNELS];
  logic [qld_pkg::CNT_W-1:0] retry_run      [qld_pkg::CHANNELS];
  logic [qld_pkg::CNT_W-1:0] next_retry_run [qld_pkg::CHANNELS];

  localparam logic [qld_pkg::CNT_W-1:0] RET_FULL = qld_pkg::CNT_W'(RETRY_CYCLES);

  // Saturates so a stuck limit cannot wrap the run length
  function automatic logic [qld_pkg::CNT_W-1:0] inc(input logic [qld_pkg::CNT_W-1:0] c);
    inc = (c == '1) ? c : c + qld_pkg::CNT_ONE;
  endfunction

  always_comb begin
    for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
      next_limit_run[i] = qld_pkg::CNT_ZERO;
      next_retry_run[i] = qld_pkg::CNT_ZERO;
      if (!logic_reset && !oc_active[i] && i_sense.current_limit[i]) begin
        next_limit_run[i] = inc(limit_run[i]);
      end
      if (!logic_reset && oc_active[i]) begin
        next_retry_run[i] = inc(retry_run[i]);
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
        limit_run[i] <= qld_pkg::CNT_ZERO;
        retry_run[i] <= qld_pkg::CNT_ZERO;
      end
    end else if (i_clk_en) begin
      for (int i = 0; i < qld_pkg::CHANNELS; i++) begin
        limit_run[i] <= next_limit_run[i];
        retry_run[i] <= next_retry_run[i];
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  property p_trip_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && !logic_reset && i_sense.thermal_trip)
        |=> (o_channel_output == '0) && !o_fault_flag_n;
  endproperty
  a_trip_off: assert property (p_trip_off) else $error("thermal trip left outputs on");

  property p_enable_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && enable_n_pin) |=> (o_channel_output == '0);
  endproperty
  a_enable_off: assert property (p_enable_off) else $error("output on while disabled");

  property p_reset_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && logic_reset) |=> (o_channel_output == '0) && o_fault_flag_n && (o_oc_fault == '0);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset did not clear state");

  property p_follow;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && !logic_reset && !enable_n_pin && !i_sense.thermal_trip && oc_active == '0)
        |=> (o_channel_output == $past(i_channel_input));
  endproperty
  a_follow: assert property (p_follow) else $error("output does not follow input");

  property p_oc_fault;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && !logic_reset && $rose(|oc_active)) |=> !o_fault_flag_n;
  endproperty
  a_oc_fault: assert property (p_oc_fault) else $error("fault line not pulled");

  property p_release;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && oc_active == '0 && !i_sense.thermal_trip) |=> o_fault_flag_n;
  endproperty
  a_release: assert property (p_release) else $error("fault line held without fault");

  property p_oe_pair;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_fault_flag_n_oe == !o_fault_flag_n;
  endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("fault enable mismatch");

  property p_no_early_trip;
    @(posedge i_clk) disable iff (!i_reset_n)
      (!i_sense.current_limit[0] && i_clk_en) |=> !$rose(oc_active[0]);
  endproperty
  a_no_early_trip: assert property (p_no_early_trip) else $error("trip without limit");

  property p_freeze;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_clk_en |=> $stable(o_channel_output) && $stable(o_fault_flag_n)
        && $stable(o_oc_fault);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");

  property p_oc_off;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_clk_en |=> ((o_channel_output & $past(oc_active)) == '0);
  endproperty
  a_oc_off: assert property (p_oc_off) else $error("driver on during retry hold");

  property p_supply;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && i_sense.supply_low)
        |=> (o_channel_output == '0) && (o_oc_fault == '0) && o_fault_flag_n;
  endproperty
  a_supply: assert property (p_supply) else $error("supply low left logic running");

  property p_float_enable;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && !i_output_enable_n_oe && !logic_reset && !i_sense.thermal_trip
        && (oc_active == '0)) |=> (o_channel_output == $past(i_channel_input));
  endproperty
  a_float_enable: assert property (p_float_enable) else $error("enable pulldown lost");

  property p_float_reset;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && !i_reset_oe && !i_sense.supply_low && !enable_n_pin
        && !i_sense.thermal_trip && (oc_active == '0))
        |=> (o_channel_output == $past(i_channel_input));
  endproperty
  a_float_reset: assert property (p_float_reset) else $error("reset pulldown lost");

  property p_resume;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && $fell(i_sense.supply_low) && !reset_pin && !enable_n_pin
        && !i_sense.thermal_trip && (oc_active == '0))
        |=> (o_channel_output == $past(i_channel_input));
  endproperty
  a_resume: assert property (p_resume) else $error("no resume after supply recovery");

  property p_heat_release;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_clk_en && $fell(i_sense.thermal_trip) && !logic_reset && !enable_n_pin
        && (oc_active == '0))
        |=> o_fault_flag_n && (o_channel_output == $past(i_channel_input));
  endproperty
  a_heat_release: assert property (p_heat_release) else $error("no thermal resume");

  // Timing checks per channel
  for (genvar g = 0; g < qld_pkg::CHANNELS; g++) begin : g_chan
    property p_deglitch_len;
      @(posedge i_clk) disable iff (!i_reset_n)
        $rose(oc_active[g]) |-> (limit_run[g] == DEG_LOAD);
    endproperty
    a_deglitch_len: assert property (p_deglitch_len) else $error("trip timing off");

    property p_retry_max;
      @(posedge i_clk) disable iff (!i_reset_n)
        oc_active[g] |-> (retry_run[g] < RET_FULL);
    endproperty
    a_retry_max: assert property (p_retry_max) else $error("retry hold overran");

    property p_retry_len;
      @(posedge i_clk) disable iff (!i_reset_n)
        ($fell(oc_active[g]) && (retry_run[g] != qld_pkg::CNT_ZERO))
          |-> (retry_run[g] == RET_FULL);
    endproperty
    a_retry_len: assert property (p_retry_len) else $error("retry hold cut short");
  end

  c_trip:   cover property (@(posedge i_clk) disable iff (!i_reset_n) $rose(oc_active[0]));
  c_recover: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(oc_active[0]));
  c_thermal: cover property (@(posedge i_clk) disable iff (!i_reset_n) $fell(i_sense.thermal_trip));
  c_drive:  cover property (@(posedge i_clk) disable iff (!i_reset_n) o_channel_output == 4'hF);
  c_frozen: cover property (@(posedge i_clk) disable iff (!i_reset_n) !i_clk_en);

endmodule

// [pkg/qld_pkg.sv]
// Package: constants and carrier types of the quad low-side driver control block
// Functional notes
// - There are four output channels, each with its own switch and its own protection state.
// - Outputs conduct only while the active-low output enable is low.
// - A floating output enable reads low, so outputs default to enabled.
// - A high reset input clears all internal logic, protection and fault state included.
// - While reset is high every other control input is ignored.
// - A floating reset input reads low, so the device is not held in reset.
// - The device makes its own reset at power-up.
// - A current limit lasting past the 3.5 us deglitch disables that driver and pulls fault low.
// - After an overcurrent trip the driver stays off for 1.2 ms, then the fault clears itself.
// - Reset or a power cycle clears an overcurrent fault at once.
// - Overtemperature turns off all switches and pulls fault low.
// - When overtemperature clears, operation and the fault line recover on their own.
// - Supply undervoltage disables everything and resets the internal logic.
// - Operation resumes once the supply is back above the lockout threshold.
// - Each channel input steers only its own output.
package qld_pkg;

  localparam int unsigned CHANNELS = 4;
  localparam int unsigned CLK_HZ   = 10_000_000;

  // Times in nanoseconds as printed
  localparam longint unsigned DEGLITCH_NS = 3_500;
  localparam longint unsigned RETRY_NS    = 1_200_000;
  localparam longint unsigned CLK_NS      = 1_000_000_000 / CLK_HZ;

  // Deglitch is a least time: round up; retry likewise held at least as long
  localparam int unsigned DEGLITCH_CYC = int'((DEGLITCH_NS + CLK_NS - 1) / CLK_NS);
  localparam int unsigned RETRY_CYC    = int'((RETRY_NS + CLK_NS - 1) / CLK_NS);

  localparam int unsigned CNT_W = 14;

  localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE  = 14'h0001;

  typedef enum logic [2:0] {
    QLD_RUN   = 3'h1,
    QLD_TRIP  = 3'h2,
    QLD_RETRY = 3'h4
  } qld_chan_state_t;

  // Per-channel protection state
  typedef struct packed {
    qld_chan_state_t  state;
    logic [CNT_W-1:0] cnt;
  } qld_chan_t;

  // Analog monitor indications
  typedef struct packed {
    logic [CHANNELS-1:0] current_limit;
    logic                thermal_trip;
    logic                supply_low;
  } qld_sense_t;

endpackage

// [bench/qld_ctrl_model.sv]
// Controller model driving the channel, enable and reset pins
module qld_ctrl_model (
  input  wire logic                        i_clk,
  output logic                             o_reset,
  output logic                             o_reset_oe,
  output logic                             o_output_enable_n,
  output logic                             o_output_enable_n_oe,
  output logic [qld_pkg::CHANNELS-1:0]     o_channel_input
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {o_reset, o_reset_oe, o_output_enable_n, o_output_enable_n_oe} = 4'h5;
    o_channel_input = 4'hF;
  end
  // Pins move just after a rising edge and then hold; a floating pin is handed a
  // high value so the pulldown, not the stale level, must decide
  task automatic drive(input logic [3:0] pins, input logic [3:0] chan);
    @(posedge i_clk);
    #10;
    {o_reset, o_reset_oe, o_output_enable_n, o_output_enable_n_oe} = pins;
    o_channel_input = chan;
  endtask
endmodule

// [bench/tb_top.sv]
// Self-checking bench of the quad low-side driver control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DG = 35;
  localparam int RT = 20;
  logic                clk;
  logic                clk_en;
  logic                rst_n;
  logic                rst;
  logic                rst_oe;
  logic                en_n;
  logic                en_oe;
  logic [3:0]          chan;
  logic [3:0]          chan_out;
  logic [3:0]          oc;
  logic                flt_n;
  logic                flt_oe;
  wire logic           fault_line;
  qld_pkg::qld_sense_t sense;
  int                  mismatches;
  int                  check_count;
  int                  cycles;
  // Open-drain fault line with its pull-up
  assign fault_line = flt_oe ? 1'b0 : 1'b1;
  qld_ctrl_model ctl (.i_clk(clk), .o_reset(rst), .o_reset_oe(rst_oe),
    .o_output_enable_n(en_n), .o_output_enable_n_oe(en_oe), .o_channel_input(chan));
  qld_control #(.DEGLITCH_CYCLES(DG), .RETRY_CYCLES(RT)) dut (.i_clk(clk), .i_reset_n(rst_n),
    .i_clk_en(clk_en), .i_reset(rst), .i_reset_oe(rst_oe), .i_output_enable_n(en_n),
    .i_output_enable_n_oe(en_oe), .i_channel_input(chan), .i_sense(sense),
    .o_channel_output(chan_out), .o_fault_flag_n(flt_n), .o_fault_flag_n_oe(flt_oe),
    .o_oc_fault(oc));
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #10;
  endtask
  task automatic trip();
    sense.current_limit = 4'h4;
    tick(DG + 1);
    sense.current_limit = 4'h0;
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      ctl.drive(4'h5, 4'(1 << i));
      tick(1);
      chk(8'(chan_out), 8'(1 << i));
    end
    ctl.drive(4'h7, 4'hF);
    tick(1);
    chk(8'(chan_out), 8'h00);
    ctl.drive(4'h6, 4'hF);
    tick(1);
    chk(8'(chan_out), 8'h0F);
    ctl.drive(4'hD, 4'hF);
    tick(1);
    chk(8'(chan_out), 8'h00);
    ctl.drive(4'h9, 4'hF);
    tick(1);
    chk(8'(chan_out), 8'h0F);
  endtask
  task automatic t_oc();
    int n;
    ctl.drive(4'h5, 4'h3);
    sense.current_limit = 4'h2;
    tick(DG - 1);
    sense.current_limit = 4'h0;
    tick(2);
    chk(8'(oc), 8'h00);
    chk(8'(chan_out), 8'h03);
    sense.current_limit = 4'h2;
    tick(DG - 1);
    chk(8'(oc), 8'h00);
    tick(1);
    chk(8'(oc), 8'h02);
    sense.current_limit = 4'h0;
    tick(1);
    chk(8'(chan_out), 8'h01);
    chk(8'(fault_line), 8'h00);
    chk(8'(flt_n), 8'h00);
    n = 1;
    while (oc[1] === 1'b1 && n < 100) begin
      tick(1);
      n++;
    end
    chk(8'(n), 8'(RT));
    tick(1);
    chk(8'(fault_line), 8'h01);
    chk(8'(chan_out), 8'h03);
    chk(8'(flt_n), 8'h01);
  endtask
  task automatic t_clear();
    ctl.drive(4'h5, 4'h7);
    trip();
    ctl.drive(4'hD, 4'h7);
    tick(1);
    chk(8'(oc), 8'h00);
    chk(8'(fault_line), 8'h01);
    ctl.drive(4'h5, 4'h7);
    tick(1);
    chk(8'(chan_out), 8'h07);
    trip();
    rst_n = 1'b0;
    tick(1);
    chk(8'(oc), 8'h00);
    chk(8'(chan_out), 8'h00);
    chk(8'(flt_n), 8'h01);
    rst_n = 1'b1;
  endtask
  task automatic t_env();
    ctl.drive(4'h5, 4'hF);
    sense.thermal_trip = 1'b1;
    tick(1);
    chk(8'(chan_out), 8'h00);
    chk(8'(fault_line), 8'h00);
    sense.thermal_trip = 1'b0;
    tick(1);
    chk(8'(chan_out), 8'h0F);
    chk(8'(fault_line), 8'h01);
    trip();
    sense.supply_low = 1'b1;
    tick(1);
    chk(8'(chan_out), 8'h00);
    chk(8'(oc), 8'h00);
    sense.supply_low = 1'b0;
    tick(1);
    chk(8'(chan_out), 8'h0F);
  endtask
  task automatic t_freeze();
    ctl.drive(4'h5, 4'h1);
    tick(1);
    chk(8'(chan_out), 8'h01);
    clk_en = 1'b0;
    ctl.drive(4'h5, 4'h8);
    sense.current_limit = 4'h8;
    tick(DG + 2);
    chk(8'(chan_out), 8'h01);
    chk(8'(oc), 8'h00);
    chk(8'(flt_n), 8'h01);
    clk_en = 1'b1;
    sense.current_limit = 4'h0;
    tick(1);
    chk(8'(chan_out), 8'h08);
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk) begin
    cycles++;
    if (cycles > 3000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n = 1'b0;
    sense = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge clk);
    #10;
    chk(8'(chan_out), 8'h00);
    chk(8'(fault_line), 8'h01);
    rst_n = 1'b1;
    t_pins();
    t_oc();
    t_clear();
    t_env();
    t_freeze();
    tally_and_finish();
  end
endmodule
